// >>> rtl/led_port_defines.svh
`ifndef LED_PORT_DEFINES_SVH
`define LED_PORT_DEFINES_SVH

// own 7-bit bus address, pattern 0110 111
`define LP_SLAVE_ADDR     7'h37
// direction bit position within the address byte
`define LP_RW_BIT         0
// direction bit value that asks for a read
`define LP_RW_READ        1'h1
// number of registers in the bank
`define LP_NUM_REGS       4
// width of a register index
`define LP_IDX_W          2
// register width in bits
`define LP_DATA_W         8
// reset value of every register
`define LP_REG_RST        8'h00
// reset value of the register pointer
`define LP_PTR_RST        8'h00
// value returned for a pointer beyond the bank
`define LP_RD_UNMAPPED    8'h00
// last bit index within a byte
`define LP_LAST_BIT       3'h7
// bit counter reset value
`define LP_CNT_RST        3'h0

`endif

// >>> rtl/led_port_pkg.sv
package led_port_pkg;

    // serial engine states, one-hot
    typedef enum logic [9:0] {
        ST_IDLE     = 10'b00_0000_0001, // bus free, waiting for a start
        ST_ADDR     = 10'b00_0000_0010, // shifting in the address byte
        ST_ADDR_ACK = 10'b00_0000_0100, // acknowledging own address
        ST_PTR      = 10'b00_0000_1000, // shifting in the pointer byte
        ST_PTR_ACK  = 10'b00_0001_0000, // acknowledging the pointer
        ST_DATA     = 10'b00_0010_0000, // shifting in a data byte
        ST_DATA_ACK = 10'b00_0100_0000, // acknowledging a data byte
        ST_RD       = 10'b00_1000_0000, // shifting out the read byte
        ST_RD_ACK   = 10'b01_0000_0000, // sampling master ack or nack
        ST_SKIP     = 10'b10_0000_0000  // released until next start or stop
    } port_state_type;

endpackage

// >>> rtl/reg_bank.sv
`timescale 1ns/1ps
`include "led_port_defines.svh"

// small register bank, one write port, registered read port
module reg_bank (
    // clock and reset
    input  wire logic                               i_ref_clk,
    input  wire logic                               i_sys_rst,
    // write port
    input  wire logic                               i_wr_en,
    input  wire logic [`LP_IDX_W-1:0]               i_wr_idx,
    input  wire logic [`LP_DATA_W-1:0]              i_wr_data,
    // read port
    input  wire logic [`LP_IDX_W-1:0]               i_rd_idx,
    output logic      [`LP_DATA_W-1:0]              o_rd_data,
    // stored values for the rest of the device
    output logic      [`LP_NUM_REGS*`LP_DATA_W-1:0] o_values
);

    // storage, one word per register
    logic [`LP_DATA_W-1:0] mem_r [`LP_NUM_REGS];

    // each register loads only on its own index
    generate
        for (genvar g = 0; g < `LP_NUM_REGS; g++) begin : g_word
            always_ff @(posedge i_ref_clk) begin
                if (i_sys_rst) begin
                    mem_r[g] <= `LP_REG_RST;
                end else if (i_wr_en && (i_wr_idx == `LP_IDX_W'(g))) begin
                    mem_r[g] <= i_wr_data;
                end
            end
            // flat copy for the downstream logic
            assign o_values[g*`LP_DATA_W +: `LP_DATA_W] = mem_r[g];
        end
    endgenerate

    // read data out of a register, one cycle behind the index
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_rd_data <= `LP_REG_RST;
        end else begin
            o_rd_data <= mem_r[i_rd_idx];
        end
    end

endmodule

// >>> rtl/led_port_slave.sv
`timescale 1ns/1ps
`include "led_port_defines.svh"

// Behaviour
// R1 - read/write slave, seven-bit addressing only
// R2 - answer address 0110111 only
// R3 - works at standard and fast rates
// R4 - four eight-bit registers reachable
// R5 - pointer never steps after a byte
// R6 - direction bit: 0 write, 1 read
// R7 - first written byte becomes the pointer
// R8 - next byte stored at pointer, acknowledged
// R9 - repeated start then read returns register
// R10 - master ends read with nack, stop
// R11 - master may talk elsewhere between phases
// R12 - pointer survives stops and foreign traffic
// R13 - start/stop frame transfers; repeated start accepted
// R14 - foreign address: no ack, bus released
module led_port_slave
    import led_port_pkg::*;
(
    // system clock and reset
    input  wire logic                               i_ref_clk,
    input  wire logic                               i_sys_rst,
    // bus clock pin, also the link clock
    input  wire logic                               i_scl,
    // bus data pin, open drain
    input  wire logic                               i_sda_in,
    output logic                                    o_sda_out,
    output logic                                    o_sda_oe,
    // register write strobe to the device
    output logic                                    o_wr_stb,
    output logic      [`LP_IDX_W-1:0]               o_wr_idx,
    output logic      [`LP_DATA_W-1:0]              o_wr_data,
    // register read strobe from the device
    output logic                                    o_rd_stb,
    // stored register values
    output logic      [`LP_NUM_REGS*`LP_DATA_W-1:0] o_reg_values,
    // pointer and activity
    output logic      [`LP_DATA_W-1:0]              o_ptr,
    output logic                                    o_busy
);

    // ---------------------------------------------------------------
    // link clock domain
    // ---------------------------------------------------------------

    // data bit captured on each rising bus clock edge
    logic                   link_bit_r;

    // sample the data line where the bus says it is valid
    always_ff @(posedge i_scl) begin
        link_bit_r <= i_sda_in;
    end

    // ---------------------------------------------------------------
    // crossings into the system clock domain
    // ---------------------------------------------------------------

    // two-flop synchronisers for both pins and the captured bit
    logic                   scl_m_r;       // first stage, clock pin
    logic                   scl_s_r;       // second stage, clock pin
    logic                   sda_m_r;       // first stage, data pin
    logic                   sda_s_r;       // second stage, data pin
    logic                   bit_m_r;       // first stage, captured bit
    logic                   bit_s_r;       // second stage, captured bit
    logic                   scl_d_r;       // delayed clock for edges
    logic                   scl_e_r;       // clock delayed twice, rise taken late so the bit has crossed
    logic                   sda_d_r;       // delayed data for edges

    // synchroniser chains, first stage read only by second
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            scl_m_r <= 1'h1;
            scl_s_r <= 1'h1;
            sda_m_r <= 1'h1;
            sda_s_r <= 1'h1;
            bit_m_r <= 1'h1;
            bit_s_r <= 1'h1;
        end else begin
            scl_m_r <= i_scl;
            scl_s_r <= scl_m_r;
            sda_m_r <= i_sda_in;
            sda_s_r <= sda_m_r;
            bit_m_r <= link_bit_r;
            bit_s_r <= bit_m_r;
        end
    end

    // one- and two-cycle history for edge detection
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            scl_d_r <= 1'h1;
            scl_e_r <= 1'h1;
            sda_d_r <= 1'h1;
        end else begin
            scl_d_r <= scl_s_r;
            scl_e_r <= scl_d_r;
            sda_d_r <= sda_s_r;
        end
    end

    // bus events seen in the system domain
    logic                   scl_rise;      // bus clock went high
    logic                   scl_fall;      // bus clock went low
    logic                   start_seen;    // data fell while clock high
    logic                   stop_seen;     // data rose while clock high

    // framing conditions come from data edges while the clock is high
    assign scl_rise   = scl_d_r && !scl_e_r; // R3
    assign scl_fall   = !scl_s_r && scl_d_r;
    assign start_seen = scl_s_r && scl_d_r && !sda_s_r && sda_d_r; // R13
    assign stop_seen  = scl_s_r && scl_d_r && sda_s_r && !sda_d_r; // R13

    // ---------------------------------------------------------------
    // address check
    // ---------------------------------------------------------------

    // true when the upper seven bits carry our own address
    function automatic logic addr_match(input logic [`LP_DATA_W-1:0] b);
        addr_match = (b[`LP_DATA_W-1:1] == `LP_SLAVE_ADDR);
    endfunction

    // true when a pointer lies inside the bank
    function automatic logic ptr_mapped(input logic [`LP_DATA_W-1:0] p);
        ptr_mapped = (p < `LP_DATA_W'(`LP_NUM_REGS));
    endfunction

    // ---------------------------------------------------------------
    // serial engine
    // ---------------------------------------------------------------

    port_state_type         state_r;       // current state
    port_state_type         state_nxt;     // next state
    logic [2:0]             cnt_r;         // bit index within byte
    logic                   byte_done_r;   // eighth bit of a byte seen
    logic [`LP_DATA_W-1:0]  rx_r;          // received bits
    logic [`LP_DATA_W-1:0]  rx_full;       // rx byte including current bit
    logic [`LP_DATA_W-1:0]  tx_r;          // bits left to send
    logic [`LP_DATA_W-1:0]  ptr_r;         // register pointer
    logic                   is_read_r;     // latched direction bit
    logic                   nack_r;        // master answered with nack
    logic [`LP_DATA_W-1:0]  rd_word;       // value of selected register
    logic [`LP_DATA_W-1:0]  bank_rd;       // registered bank output
    logic                   rx_state;      // states that shift bits in

    // states in which the master drives bits to us
    assign rx_state = (state_r == ST_ADDR) || (state_r == ST_PTR) || (state_r == ST_DATA);

    // completed byte as it would be after the current rising edge
    assign rx_full = {rx_r[`LP_DATA_W-2:0], bit_s_r};

    // unmapped pointers read back a fixed value
    assign rd_word = ptr_mapped(ptr_r) ? bank_rd : `LP_RD_UNMAPPED; // R4

    // state transitions
    always_comb begin
        state_nxt = state_r;
        if (stop_seen) begin
            // stop ends any frame
            state_nxt = ST_IDLE; // R13
        end else if (start_seen) begin
            // start or repeated start always restarts addressing
            state_nxt = ST_ADDR; // R13
        end else if (scl_fall) begin
            unique case (state_r)
                ST_IDLE: begin
                    state_nxt = ST_IDLE;
                end
                ST_ADDR: begin
                    // ack own address, otherwise let go of the bus
                    if (byte_done_r) begin
                        state_nxt = addr_match(rx_r) ? ST_ADDR_ACK : ST_SKIP; // R2 R14
                    end
                end
                ST_ADDR_ACK: begin
                    // direction bit picks the next phase
                    state_nxt = is_read_r ? ST_RD : ST_PTR; // R6
                end
                ST_PTR: begin
                    if (byte_done_r) begin
                        state_nxt = ST_PTR_ACK;
                    end
                end
                ST_PTR_ACK: begin
                    state_nxt = ST_DATA;
                end
                ST_DATA: begin
                    if (byte_done_r) begin
                        state_nxt = ST_DATA_ACK;
                    end
                end
                ST_DATA_ACK: begin
                    // further bytes land on the same register
                    state_nxt = ST_DATA; // R5
                end
                ST_RD: begin
                    if (byte_done_r) begin
                        state_nxt = ST_RD_ACK;
                    end
                end
                ST_RD_ACK: begin
                    // ack repeats the same register, nack waits for stop
                    state_nxt = nack_r ? ST_SKIP : ST_RD; // R10 R5
                end
                ST_SKIP: begin
                    state_nxt = ST_SKIP;
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // bit counter, cleared by framing and at each byte boundary
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || start_seen || stop_seen) begin
            cnt_r       <= `LP_CNT_RST;
            byte_done_r <= 1'h0;
        end else if (scl_fall && byte_done_r) begin
            // acknowledge slot follows, count restarts after it
            cnt_r       <= `LP_CNT_RST;
            byte_done_r <= 1'h0;
        end else if (scl_rise && (rx_state || (state_r == ST_RD))) begin
            cnt_r       <= cnt_r + 3'h1;
            byte_done_r <= (cnt_r == `LP_LAST_BIT);
        end
    end

    // receive shift register, msb first; all eight bits, direction bit included
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rx_r <= `LP_REG_RST;
        end else if (scl_rise && rx_state) begin
            rx_r <= rx_full; // R1
        end
    end

    // direction bit latched with the last address bit
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            is_read_r <= 1'h0;
        end else if (scl_rise && (state_r == ST_ADDR) && (cnt_r == `LP_LAST_BIT)) begin
            is_read_r <= (bit_s_r == `LP_RW_READ); // R6
        end
    end

    // master answer after a read byte; high means nack
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            nack_r <= 1'h0;
        end else if (scl_rise && (state_r == ST_RD_ACK)) begin
            nack_r <= bit_s_r; // R10
        end
    end

    // pointer loads from the first written byte and is kept otherwise
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ptr_r <= `LP_PTR_RST;
        end else if (scl_fall && (state_r == ST_PTR) && byte_done_r) begin
            ptr_r <= rx_r; // R7 R12
        end
    end

    // transmit shift register, loaded as the read phase opens
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            tx_r <= `LP_REG_RST;
        end else if (scl_fall && (state_r == ST_ADDR_ACK) && is_read_r) begin
            tx_r <= rd_word; // R9 R12
        end else if (scl_fall && (state_r == ST_RD_ACK) && !nack_r) begin
            tx_r <= rd_word; // R5
        end else if (scl_fall && (state_r == ST_RD) && !byte_done_r) begin
            tx_r <= {tx_r[`LP_DATA_W-2:0], 1'h0};
        end
    end

    // data line drive, set only while the clock is low, released at start and stop
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || start_seen || stop_seen) begin
            o_sda_oe <= 1'h0;
        end else if (scl_fall) begin
            unique case (state_nxt)
                ST_ADDR_ACK, ST_PTR_ACK, ST_DATA_ACK: begin
                    // pull low for acknowledge
                    o_sda_oe <= 1'h1; // R8
                end
                ST_RD: begin
                    // open drain: drive only the zero bits
                    if (state_r == ST_RD) begin
                        o_sda_oe <= !tx_r[`LP_DATA_W-2];
                    end else begin
                        o_sda_oe <= !rd_word[`LP_DATA_W-1]; // R9
                    end
                end
                default: begin
                    // released, including foreign addresses
                    o_sda_oe <= 1'h0; // R14
                end
            endcase
        end
    end

    // the pin only ever pulls low
    assign o_sda_out = 1'h0;

    // write strobe as the data byte is acknowledged
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_wr_stb  <= 1'h0;
            o_wr_idx  <= '0;
            o_wr_data <= `LP_REG_RST;
        end else begin
            o_wr_stb  <= scl_fall && (state_r == ST_DATA) && byte_done_r && ptr_mapped(ptr_r); // R8
            o_wr_idx  <= ptr_r[`LP_IDX_W-1:0];
            o_wr_data <= rx_r;
        end
    end

    // read strobe as a byte is loaded for sending
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_rd_stb <= 1'h0;
        end else begin
            o_rd_stb <= scl_fall && (((state_r == ST_ADDR_ACK) && is_read_r)
                        || ((state_r == ST_RD_ACK) && !nack_r));
        end
    end

    // activity flag, set while a frame is open
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_busy <= 1'h0;
        end else begin
            o_busy <= (state_nxt != ST_IDLE);
        end
    end

    // pointer visible to the device
    assign o_ptr = ptr_r;

    // ---------------------------------------------------------------
    // register bank
    // ---------------------------------------------------------------

    // four eight-bit registers, read always follows the pointer
    reg_bank u_bank (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_wr_en   (o_wr_stb),
        .i_wr_idx  (o_wr_idx),
        .i_wr_data (o_wr_data),
        .i_rd_idx  (ptr_r[`LP_IDX_W-1:0]),
        .o_rd_data (bank_rd),
        .o_values  (o_reg_values)
    ); // R4

endmodule

// >>> verif/i2c_master_model.sv
`timescale 1ns/1ps
// behavioural two-wire bus master; clock stands high between frames
module i2c_master_model (
    // bus clock driven by this master
    output logic      o_scl,
    // high pulls the data line low
    output logic      o_sda_low,
    // resolved data line level
    input  wire logic i_sda
);
    int q = 625; // quarter bit time in ns, 625 gives 400 kbit/s, 2500 gives 100 kbit/s
    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end
    // start, or repeated start when the clock is low
    task automatic bus_start();
        if (!o_scl) begin
            o_sda_low = 1'b0;
            #q;
            o_scl = 1'b1;
            #q;
        end
        o_sda_low = 1'b1;
        #q;
        o_scl = 1'b0;
        #q;
    endtask
    // stop: data rises while clock high
    task automatic bus_stop();
        o_sda_low = 1'b1;
        #q;
        o_scl = 1'b1;
        #q;
        o_sda_low = 1'b0;
        #q;
    endtask
    // one bit slot: data set while clock low, sampled mid high
    task automatic bus_bit(input logic b, output logic s);
        o_sda_low = !b;
        #q;
        o_scl = 1'b1;
        #q;
        s = i_sda;
        #q;
        o_scl = 1'b0;
        #q;
    endtask
    // byte out msb first, then the slave's ack slot
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bus_bit(b[i], s);
        end
        bus_bit(1'b1, s);
        ack = !s;
    endtask
    // byte in msb first, then our ack or nack
    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bus_bit(1'b1, s);
            d[i] = s;
        end
        bus_bit(nack, s);
    endtask
endmodule

// >>> verif/led_port_slave_asserts.sv
`timescale 1ns/1ps
`include "led_port_defines.svh"
// port-level checks on the serial slave
module led_port_slave_asserts (
    input wire logic                               i_ref_clk,
    input wire logic                               i_sys_rst,
    input wire logic                               i_scl,
    input wire logic                               i_sda_in,
    input wire logic                               o_sda_out,
    input wire logic                               o_sda_oe,
    input wire logic                               o_wr_stb,
    input wire logic [`LP_IDX_W-1:0]               o_wr_idx,
    input wire logic [`LP_DATA_W-1:0]              o_wr_data,
    input wire logic                               o_rd_stb,
    input wire logic [`LP_NUM_REGS*`LP_DATA_W-1:0] o_reg_values,
    input wire logic [`LP_DATA_W-1:0]              o_ptr,
    input wire logic                               o_busy
);
    logic [1:0] idx_h;  // index of the last write
    logic [7:0] data_h; // data of the last write
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    // hold the last write for the landing check
    always_ff @(posedge i_ref_clk) begin
        if (o_wr_stb) begin
            idx_h  <= o_wr_idx;
            data_h <= o_wr_data;
        end
    end
    a_sda_pull_low: assert property (o_sda_out == 1'b0)
        else $error("data output not zero");
    a_wr_one_cycle: assert property (o_wr_stb |=> !o_wr_stb)
        else $error("write strobe too long");
    a_wr_at_ptr: assert property (o_wr_stb |-> (o_ptr < 8'h04) && (o_wr_idx == o_ptr[1:0]))
        else $error("write index not the pointer");
    a_wr_stored: assert property (o_wr_stb |-> ##[1:2] (o_reg_values[8*idx_h +: 8] == data_h))
        else $error("written data not stored");
    a_rd_one_cycle: assert property (o_rd_stb |=> !o_rd_stb)
        else $error("read strobe too long");
    a_oe_rise_low: assert property ($rose(o_sda_oe) |-> !i_scl)
        else $error("data driven while clock high");
    a_ptr_in_frame: assert property ($changed(o_ptr) |-> o_busy || $past(o_busy))
        else $error("pointer changed outside a frame");
    a_regs_by_write: assert property ($changed(o_reg_values) |-> $past(o_wr_stb) || $past(o_wr_stb, 2))
        else $error("register changed without write");
    a_idle_released: assert property (!o_busy && !$past(o_busy) |-> !o_sda_oe)
        else $error("data pulled while idle");
endmodule
bind led_port_slave led_port_slave_asserts u_chk (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_sda_in(i_sda_in),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_wr_stb(o_wr_stb), .o_wr_idx(o_wr_idx),
    .o_wr_data(o_wr_data), .o_rd_stb(o_rd_stb), .o_reg_values(o_reg_values), .o_ptr(o_ptr),
    .o_busy(o_busy)
);

// >>> verif/test_led_port_slave.sv
`timescale 1ns/1ps
`include "led_port_defines.svh"
// serial slave bench: a bus master model drives every transfer
module test_led_port_slave;
    logic        i_ref_clk = 1'b0; // 25 MHz system clock
    logic        i_sys_rst = 1'b1; // synchronous reset
    wire         scl;              // bus clock from the master
    wire         sda_low;          // master pulls data low
    wire         sda;              // resolved data line, pulled up
    logic        sda_out, sda_oe, wr_stb, rd_stb, busy;
    logic [1:0]  wr_idx;
    logic [7:0]  wr_data, ptr;
    logic [31:0] reg_values;
    logic [7:0]  regs [4];         // expected register contents
    int          fails = 0, comparisons = 0, wr_cnt = 0, oe_cnt = 0, rd_cnt = 0;
    logic        watch = 1'b0;     // counts data pulls while set
    assign sda = !(sda_low || (sda_oe && sda_out === 1'b0));
    always #20 i_ref_clk = ~i_ref_clk;
    // count write strobes and unwanted data pulls
    always @(posedge i_ref_clk) begin
        wr_cnt <= wr_cnt + int'(wr_stb);
        rd_cnt <= rd_cnt + int'(rd_stb);
        oe_cnt <= oe_cnt + int'(watch && sda_oe);
    end
    i2c_master_model m (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));
    led_port_slave dut (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda_in(sda),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_wr_stb(wr_stb), .o_wr_idx(wr_idx),
        .o_wr_data(wr_data), .o_rd_stb(rd_stb), .o_reg_values(reg_values), .o_ptr(ptr),
        .o_busy(busy)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask
    task automatic stop_test();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // select a register, optionally closing with a stop
    task automatic set_ptr(input logic [7:0] p, input logic do_stop);
        logic a;
        m.bus_start();
        m.wr_byte(8'h6E, a);
        chk(a, 1'b1);
        m.wr_byte(p, a);
        chk(a, 1'b1);
        chk(ptr, p);
        if (do_stop) m.bus_stop();
    endtask
    // write one register and compare the bank
    task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
        logic a;
        set_ptr(p, 1'b0);
        m.wr_byte(d, a);
        chk(a, 1'b1);
        m.bus_stop();
        if (p < 8'h04) regs[p[1:0]] = d;
        chk(reg_values, {regs[3], regs[2], regs[1], regs[0]});
    endtask
    // read n bytes from the current pointer, nack on the last
    task automatic rd_cur(input int n, input logic [7:0] exp);
        logic       a;
        logic [7:0] d;
        int         r0;
        r0 = rd_cnt;
        m.bus_start();
        m.wr_byte(8'h6F, a);
        chk(a, 1'b1);
        for (int k = 0; k < n; k++) begin
            m.rd_byte(k == n - 1, d);
            chk(d, exp);
        end
        m.bus_stop();
        repeat (6) @(posedge i_ref_clk);
        chk(busy, 1'b0);
        chk(rd_cnt, r0 + n);
    endtask
    task automatic t_write();
        for (int r = 0; r < 4; r++) wr_reg(r[7:0], 8'hA5 ^ (8'h11 << r));
        chk(wr_cnt, 4);
        $display("test write done");
    endtask
    task automatic t_combined();
        for (int r = 3; r >= 0; r--) begin
            set_ptr(r[7:0], 1'b0);
            rd_cur(1, regs[r]);
        end
        $display("test combined read done");
    endtask
    // pointer kept over a stop, foreign addresses and a restart
    task automatic t_separate();
        logic             a;
        logic [7:0] other [3] = '{8'hA0, 8'h6C, 8'hF0};
        set_ptr(8'h02, 1'b1);
        watch = 1'b1;
        foreach (other[i]) begin
            m.bus_start();
            m.wr_byte(other[i], a);
            chk(a, 1'b0);
        end
        m.bus_stop();
        chk(oe_cnt, 0);
        watch = 1'b0;
        rd_cur(1, regs[2]);
        set_ptr(8'h01, 1'b0);
        m.bus_start();
        m.wr_byte(8'hA1, a);
        chk(a, 1'b0);
        rd_cur(1, regs[1]);
        $display("test separate read done");
    endtask
    // pointer beyond the bank: acked, nothing stored, reads zero
    task automatic t_unmapped();
        int w0;
        w0 = wr_cnt;
        wr_reg(8'h04, 8'h3C);
        chk(wr_cnt, w0);
        set_ptr(8'h04, 1'b0);
        rd_cur(1, 8'h00);
        $display("test unmapped done");
    endtask
    // two data bytes and two reads all hit one register
    task automatic t_no_step();
        logic a;
        set_ptr(8'h03, 1'b0);
        m.wr_byte(8'h11, a);
        chk(a, 1'b1);
        m.wr_byte(8'h22, a);
        chk(a, 1'b1);
        m.bus_stop();
        regs[3] = 8'h22;
        chk(reg_values, {regs[3], regs[2], regs[1], regs[0]});
        chk(ptr, 8'h03);
        rd_cur(2, 8'h22);
        $display("test no step done");
    endtask
    task automatic t_standard();
        m.q = 2500;
        wr_reg(8'h00, 8'h5A);
        set_ptr(8'h00, 1'b0);
        rd_cur(1, 8'h5A);
        m.q = 625;
        $display("test standard rate done");
    endtask
    initial begin
        #3ms;
        fails++;
        stop_test();
    end
    initial begin
        foreach (regs[i]) regs[i] = 8'h00;
        repeat (20) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        chk(reg_values, 32'h0000_0000);
        chk(ptr, 8'h00);
        chk(busy, 1'b0);
        t_write();
        t_combined();
        t_separate();
        t_unmapped();
        t_no_step();
        t_standard();
        stop_test();
    end
endmodule
